// ==== design/cpsc_top.sv ====
// Purpose: power-up clear, pin sleep and register force for the array
// Assumes: one 40 MHz clock; inputs synchronous; reset_i models supply
//          crossing supply_reset_threshold
// Notes:   macrocell logic itself lives outside; d_i is its next state
// Operation
// RULE1: after supply reset, every register clears low.
// RULE2: board keeps clock sources stable through the reset interval.
// RULE3: board meets setup before the first clock after reset.
// RULE4: sleep_request powers down only when enabled by configuration.
// RULE5: in sleep, all state and outputs are held.
// RULE6: outputs high-z at sleep entry remain high-z.
// RULE7: in sleep, all inputs except sleep_request are ignored. Here sleep_enable_i is not ignored: dropping it also ends sleep.
// RULE8: pin keepers stay active in sleep.
// RULE9: enabled sleep pin is unavailable to the logic array.
// RULE10: up to 1 us wake delay after sleep_request falls.
// RULE11: test path forces any register high or low.
// RULE12: tester enters force mode by raising a pin to high voltage.
// RULE13: wake resumes from held state without any reset.
`include "cpsc_map.svh"
module cpsc_top #(
  parameter int N_CELLS      = 32,
  parameter int RESET_CYCLES = `CPSC_RESET_CYCLES,
  parameter int WAKE_CYCLES  = `CPSC_WAKE_CYCLES
) (
  input  wire logic               ref_clk_i,
  input  wire logic               reset_i,
  input  wire logic               sleep_enable_i,
  input  wire logic               sleep_request_i,
  input  wire logic               force_mode_i,
  input  wire logic [N_CELLS-1:0] force_sel_i,
  input  wire logic [N_CELLS-1:0] force_val_i,
  input  wire logic [N_CELLS-1:0] d_i,
  input  wire logic [N_CELLS-1:0] oe_i,
  input  wire logic [N_CELLS-1:0] pin_i,
  input  wire logic [N_CELLS-1:0] pin_oe_i,
  output logic [N_CELLS-1:0]      q_o,
  output logic [N_CELLS-1:0]      oe_o,
  output logic [N_CELLS-1:0]      keep_o,
  output logic                    sleep_pin_array_o,
  output logic                    asleep_o,
  output logic                    ready_o
);
  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // wake check window is a delay range, so it must stay short
  localparam int WAKE_LIMIT = WAKE_CYCLES + 1;

  if (N_CELLS < 1 || RESET_CYCLES < 1 || WAKE_CYCLES < 1 ||
      RESET_CYCLES >= (1 << `CPSC_CNT_W) || WAKE_CYCLES >= (1 << `CPSC_CNT_W) ||
      WAKE_LIMIT > `CPSC_RANGE_MAX) begin : g_bad_params
    $error("cpsc_top: unsupported parameter values");
  end

  localparam logic [`CPSC_CNT_W-1:0] RST_LAST  = `CPSC_CNT_W'(RESET_CYCLES - 1);
  localparam logic [`CPSC_CNT_W-1:0] WAKE_LAST = `CPSC_CNT_W'(WAKE_CYCLES - 1);
  localparam logic [`CPSC_CNT_W-1:0] CNT_ZERO  = '0;

  cpsc_pkg::cpsc_state_t state_reg;
  cpsc_pkg::cpsc_state_t state_next;
  logic [`CPSC_CNT_W-1:0] cnt_reg;
  logic                   sleep_req;
  logic                   hold;
  logic                   clear;
  logic                   force_en;

  // gated by configuration; sleep pin never reaches the array when enabled
  assign sleep_req = sleep_enable_i && sleep_request_i; // RULE4
  assign clear     = (state_reg == cpsc_pkg::CPSC_POR);
  // hold through wake too: inputs are not valid until the delay ends
  assign hold      = (state_reg == cpsc_pkg::CPSC_SLEEP) ||
                     (state_reg == cpsc_pkg::CPSC_WAKE); // RULE7
  assign force_en  = force_mode_i && !hold && !clear;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cpsc_pkg::CPSC_POR: begin
        if (cnt_reg == RST_LAST) begin
          state_next = cpsc_pkg::CPSC_RUN;
        end
      end
      cpsc_pkg::CPSC_RUN: begin
        if (sleep_req) begin
          state_next = cpsc_pkg::CPSC_SLEEP;
        end
      end
      cpsc_pkg::CPSC_SLEEP: begin
        if (!sleep_req) begin
          state_next = cpsc_pkg::CPSC_WAKE;
        end
      end
      cpsc_pkg::CPSC_WAKE: begin
        if (sleep_req) begin
          state_next = cpsc_pkg::CPSC_SLEEP;
        end else if (cnt_reg == WAKE_LAST) begin
          state_next = cpsc_pkg::CPSC_RUN; // RULE13
        end
      end
      default: begin
        state_next = cpsc_pkg::CPSC_POR;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg <= cpsc_pkg::CPSC_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // interval counter
  // ----------------------------------------
  // one counter serves both the reset interval and the wake delay
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || state_next != state_reg) begin
      cnt_reg <= CNT_ZERO;
    end else if (state_reg == cpsc_pkg::CPSC_POR || state_reg == cpsc_pkg::CPSC_WAKE) begin
      cnt_reg <= cnt_reg + 1'b1; // RULE10
    end
  end

  // separate age of the clear phase, so its check does not lean on cnt_reg
  logic [`CPSC_CNT_W-1:0] por_age_reg;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || state_reg != cpsc_pkg::CPSC_POR) begin
      por_age_reg <= CNT_ZERO;
    end else begin
      por_age_reg <= por_age_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      asleep_o          <= 1'b0;
      ready_o           <= 1'b0;
      sleep_pin_array_o <= 1'b0;
    end else begin
      asleep_o          <= (state_next == cpsc_pkg::CPSC_SLEEP);
      ready_o           <= (state_next == cpsc_pkg::CPSC_RUN);
      sleep_pin_array_o <= sleep_enable_i ? 1'b0 : sleep_request_i; // RULE9
    end
  end

  // ----------------------------------------
  // macrocells
  // ----------------------------------------
  for (genvar i = 0; i < N_CELLS; i++) begin : g_cell
    cpsc_cell u_cell (
      .ref_clk_i  (ref_clk_i),
      .clear_i    (clear),
      .hold_i     (hold),
      .force_en_i (force_en && force_sel_i[i]), // RULE11
      .force_val_i(force_val_i[i]),
      .d_i        (d_i[i]),
      .oe_i       (oe_i[i]),
      .pin_i      (pin_i[i]),
      .pin_oe_i   (pin_oe_i[i]),
      .q_o        (q_o[i]),
      .oe_o       (oe_o[i]),
      .keep_o     (keep_o[i])
    );
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_por_clears: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $past(clear) |-> (q_o == '0 && oe_o == '0)) // RULE1
    else $error("registers not cleared in power-up interval");
  a_por_interval: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_reg == cpsc_pkg::CPSC_POR) |-> (por_age_reg < RESET_CYCLES)) // RULE1
    else $error("power-up clear outlasted its interval");
  a_sleep_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_reg == cpsc_pkg::CPSC_RUN && sleep_request_i && !sleep_enable_i) |=> !asleep_o) // RULE4
    else $error("sleep entered while feature disabled");
  a_hold_q: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ($past(hold) && !$past(reset_i)) |-> $stable(q_o)) // RULE5
    else $error("register changed while held");
  a_hold_oe: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ($past(hold) && !$past(reset_i)) |-> $stable(oe_o)) // RULE6
    else $error("output enable changed while held");
  a_hold_keep: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ($past(hold) && !$past(reset_i)) |-> $stable(keep_o)) // RULE8
    else $error("keeper changed while held");
  a_inputs_blocked: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    hold |-> !force_en) // RULE7
    else $error("force path open while held");
  a_pin_array: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $past(sleep_enable_i) |-> !sleep_pin_array_o) // RULE9
    else $error("sleep pin reached logic array");
  a_wake_bound: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_reg == cpsc_pkg::CPSC_SLEEP && !sleep_req) |-> ##[1:WAKE_LIMIT] (ready_o || asleep_o)) // RULE10
    else $error("wake delay overrun");
  a_wake_run: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_reg == cpsc_pkg::CPSC_WAKE && !sleep_req && cnt_reg == WAKE_LAST) |=> ready_o) // RULE13
    else $error("wake did not resume run");
  a_force_val: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (force_en && force_sel_i[0]) |=> (q_o[0] == $past(force_val_i[0]))) // RULE11
    else $error("forced value not loaded");

  c_sleep: cover property (@(posedge ref_clk_i) disable iff (reset_i) $rose(asleep_o));
  c_wake: cover property (@(posedge ref_clk_i) disable iff (reset_i) $fell(asleep_o) ##[1:60] ready_o);
  c_force: cover property (@(posedge ref_clk_i) disable iff (reset_i) force_en);
  c_sleep_gated: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    state_reg == cpsc_pkg::CPSC_RUN && sleep_request_i && sleep_enable_i);
  c_sleep_off: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    state_reg == cpsc_pkg::CPSC_RUN && sleep_request_i && !sleep_enable_i);
endmodule

// ==== design/cpsc_map.svh ====
// Purpose: named constants for the power state controller
// Assumes: 40 MHz reference clock
// Notes:   times in their own unit, cycle counts derived
`ifndef CPSC_MAP_SVH
`define CPSC_MAP_SVH
`define CPSC_CLK_MHZ          40
`define CPSC_RESET_INTERVAL_US 10
`define CPSC_WAKE_US          1
`define CPSC_RESET_CYCLES     (`CPSC_RESET_INTERVAL_US * `CPSC_CLK_MHZ)
`define CPSC_WAKE_CYCLES      (`CPSC_WAKE_US * `CPSC_CLK_MHZ)
`define CPSC_CNT_W            12
`define CPSC_RANGE_MAX        1000
`define CPSC_ALL_LOW          1'b0
`endif

// ==== design/cpsc_pkg.sv ====
// Purpose: types for the power state controller
// Assumes: nothing
// Notes:   state encoding left to the tool
package cpsc_pkg;
  typedef enum logic [2:0] {
    CPSC_POR,
    CPSC_RUN,
    CPSC_SLEEP,
    CPSC_WAKE
  } cpsc_state_t;
endpackage

// ==== design/cpsc_cell.sv ====
// Purpose: one held macrocell register with force path and pin keeper
// Assumes: controls come from the sequencer, all synchronous
// Notes:   register, output enable and keeper all freeze while held
`include "cpsc_map.svh"
module cpsc_cell (
  input  wire logic ref_clk_i,
  input  wire logic clear_i,
  input  wire logic hold_i,
  input  wire logic force_en_i,
  input  wire logic force_val_i,
  input  wire logic d_i,
  input  wire logic oe_i,
  input  wire logic pin_i,
  input  wire logic pin_oe_i,
  output logic      q_o,
  output logic      oe_o,
  output logic      keep_o
);
  // ----------------------------------------
  // register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (clear_i) begin
      q_o <= `CPSC_ALL_LOW; // RULE1
    end else if (force_en_i) begin
      q_o <= force_val_i; // RULE11
    end else if (!hold_i) begin
      q_o <= d_i; // RULE5
    end
  end

  // high-z outputs stay high-z while held
  always_ff @(posedge ref_clk_i) begin
    if (clear_i) begin
      oe_o <= `CPSC_ALL_LOW;
    end else if (!hold_i) begin
      oe_o <= oe_i; // RULE6
    end
  end

  // keeper tracks the pin only when someone drives it
  always_ff @(posedge ref_clk_i) begin
    if (clear_i) begin
      keep_o <= `CPSC_ALL_LOW;
    end else if (!hold_i && pin_oe_i) begin
      keep_o <= pin_i; // RULE8
    end
  end
endmodule

// ==== test/cpsc_board.sv ====
// Purpose: board logic around the controller: data, pins, sleep, force
// Assumes: everything changes on the falling edge of the clock
// Notes:   a released pin shows the inverse of its last level
module cpsc_board #(
  parameter int N = 4
) (
  input  wire logic   clk_i,
  input  wire logic   ready_i,
  output logic        sleep_o,
  output logic        force_o,
  output logic [N-1:0] sel_o,
  output logic [N-1:0] val_o,
  output logic [N-1:0] d_o,
  output logic [N-1:0] oe_o,
  output logic [N-1:0] pin_o,
  output logic [N-1:0] pe_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // waits for ready that ran out of patience; counted here, the bench checks for none
  int stalls = 0;

  // quiet lines from time zero are set up before the first clock edge
  initial begin
    {sleep_o, force_o, sel_o, val_o, d_o, oe_o, pin_o, pe_o} = '0;
  end

  // w=0 only where a scenario drives data into a blocked device
  task automatic set_data(input logic [N-1:0] d, o, p, pe, input bit w);
    int k;
    k = 0;
    while (w && ready_i !== 1'b1 && k < 200) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 200) begin
      stalls++;
    end
    @(negedge clk_i);
    d_o = d;
    oe_o = o;
    pin_o = (p & pe) | (~pin_o & ~pe);
    pe_o = pe;
  endtask

  task automatic set_sleep(input logic s);
    @(negedge clk_i);
    sleep_o = s;
  endtask

  // stands for the elevated-voltage pin of the tester
  task automatic set_force(input logic f, input logic [N-1:0] s, v);
    @(negedge clk_i);
    force_o = f;
    sel_o = s;
    val_o = v;
  endtask
endmodule

// ==== test/test_cpsc_top.sv ====
// Purpose: self-checking bench for the power state controller
// Assumes: short reset and wake counts of 4 cycles
// Notes:   bench drives at the falling edge and samples there too
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module test_cpsc_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N = 4;
  localparam int RC = 4;
  localparam int WC = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        en = 1'b0;
  logic        slp, frc, rdy;
  logic [N-1:0] sel, val, d, oe, pin, pe;
  int          error_cnt = 0;
  int          check_count = 0;
  int          n;

  initial begin
    forever #12.5 clk = ~clk;
  end

  cpsc_board #(.N(N)) b (.clk_i(clk), .ready_i(rdy), .sleep_o(slp), .force_o(frc),
    .sel_o(sel), .val_o(val), .d_o(d), .oe_o(oe), .pin_o(pin), .pe_o(pe));

  cpsc_top #(.N_CELLS(N), .RESET_CYCLES(RC), .WAKE_CYCLES(WC)) i_dut (
    .ref_clk_i(clk), .reset_i(rst), .sleep_enable_i(en), .sleep_request_i(slp),
    .force_mode_i(frc), .force_sel_i(sel), .force_val_i(val), .d_i(d), .oe_i(oe),
    .pin_i(pin), .pin_oe_i(pe), .q_o(), .oe_o(), .keep_o(), .sleep_pin_array_o(),
    .asleep_o(), .ready_o(rdy));

  task automatic close_out();
    `CHK(b.stalls, 0)
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // bounded wait for ready, n counts falling edges seen
  task automatic wait_rdy();
    n = 0;
    while (rdy !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 100) begin
        error_cnt++;
        close_out();
      end
    end
  endtask

  task automatic t_por();
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    wait_rdy();
    `CHK(n, RC)
    `CHK(i_dut.q_o, 4'h0)
    $display("power-up clear done");
  endtask

  task automatic t_run();
    b.set_data(4'hA, 4'h6, 4'h3, 4'hF, 1'b1);
    @(negedge clk);
    `CHK({i_dut.q_o, i_dut.oe_o, i_dut.keep_o}, 12'hA63)
    $display("run capture done");
  endtask

  task automatic t_sleep();
    en = 1'b1;
    b.set_sleep(1'b1);
    repeat (2) @(negedge clk);
    `CHK({i_dut.asleep_o, rdy}, 2'b10)
    b.set_data(4'h5, 4'h9, 4'hC, 4'hF, 1'b0);
    b.set_force(1'b1, 4'hF, 4'hF);
    repeat (3) @(negedge clk);
    `CHK({i_dut.q_o, i_dut.keep_o}, 8'hA3)
    `CHK(i_dut.oe_o, 4'h6)
    `CHK(i_dut.sleep_pin_array_o, 1'b0)
    b.set_force(1'b0, 4'h0, 4'h0);
    b.set_sleep(1'b0);
    wait_rdy();
    `CHK(n >= WC && n <= WC + 2, 1'b1)
    `CHK(i_dut.q_o, 4'hA)
    @(negedge clk);
    `CHK(i_dut.q_o, 4'h5)
    $display("sleep and wake done");
  endtask

  task automatic t_nosleep();
    en = 1'b0;
    b.set_sleep(1'b1);
    b.set_data(4'h3, 4'h6, 4'h3, 4'hF, 1'b1);
    repeat (2) @(negedge clk);
    `CHK({i_dut.asleep_o, rdy, i_dut.q_o}, 6'h13)
    `CHK(i_dut.sleep_pin_array_o, 1'b1)
    b.set_sleep(1'b0);
    $display("sleep disabled done");
  endtask

  // sleep rises again while the wake delay is still running
  task automatic t_resleep();
    en = 1'b1;
    b.set_sleep(1'b1);
    repeat (2) @(negedge clk);
    b.set_sleep(1'b0);
    b.set_sleep(1'b1);
    @(negedge clk);
    `CHK({i_dut.asleep_o, rdy}, 2'b10)
    b.set_sleep(1'b0);
    wait_rdy();
    `CHK(n, WC + 1)
    en = 1'b0;
    $display("sleep during wake done");
  endtask

  task automatic t_force();
    b.set_force(1'b1, 4'h5, 4'h1);
    b.set_data(4'hF, 4'h6, 4'h3, 4'h0, 1'b1);
    @(negedge clk);
    `CHK(i_dut.q_o, 4'hB)
    b.set_force(1'b0, 4'h0, 4'h0);
    $display("force done");
  endtask

  initial begin
    t_por();
    t_run();
    t_sleep();
    t_nosleep();
    t_resleep();
    t_force();
    t_por();
    close_out();
  end
endmodule
